// ### rtl/rcs_pkg.sv
/*
 * reset-cause status block: shared offsets, field positions, reset
 * values, state codes and timing counts.
 * assumes a 50 MHz system clock and a 32-bit apb register port.
 */
package rcs_pkg;

	// -----------------------------------------------------------------
	// register map (byte addresses)
	// -----------------------------------------------------------------
	localparam logic [7:0] RCS_OFS_CAUSE = 8'h00; // reset_cause_status
	localparam logic [7:0] RCS_OFS_CTRL = 8'h04; // regulator control
	localparam logic [7:0] RCS_OFS_STAT = 8'h08; // live state, read only

	// -----------------------------------------------------------------
	// reset_cause_status fields
	// -----------------------------------------------------------------
	localparam int RCS_BIT_POR = 0; // power-on flag
	localparam int RCS_BIT_BOR = 1; // brown-out flag
	localparam int RCS_BIT_IDLE = 2; // idle history flag
	localparam int RCS_BIT_SLEEP = 3; // sleep history flag
	localparam int RCS_BIT_WATCHDOG_TIMEOUT_FLAG = 4; // watchdog time-out flag
	localparam int RCS_BIT_SWDT = 5; // sw_watchdog_enable
	localparam int RCS_NFLAG = 5; // hardware-set flags
	localparam logic [5:0] RCS_CAUSE_RST = 6'h03; // power-on sets por and bor

	// -----------------------------------------------------------------
	// control and live status fields
	// -----------------------------------------------------------------
	localparam int RCS_BIT_RETENTION_REGULATOR_ENABLE = 0; // retention_regulator_enable
	localparam int RCS_BIT_NODLY = 1; // skip the regulator wake delay
	localparam logic [1:0] RCS_CTRL_RST = 2'h0;
	localparam int RCS_BIT_WRUN = 0; // watchdog running
	localparam int RCS_BIT_RACT = 1; // retention regulator on
	localparam int RCS_BIT_WBUSY = 2; // wake sequence busy

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int RCS_CLK_NS = 20; // 50 MHz
	localparam int RCS_WDT_PERIOD_NS = 1000000; // watchdog period, longest
	localparam int RCS_WDT_CYC = RCS_WDT_PERIOD_NS / RCS_CLK_NS;
	localparam int RCS_REGULATOR_WAKE_DELAY_NS = 10000; // regulator_wake_delay, least
	localparam int RCS_DLY_CYC = (RCS_REGULATOR_WAKE_DELAY_NS + RCS_CLK_NS - 1) / RCS_CLK_NS;

	// -----------------------------------------------------------------
	// wake sequencer states
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		RCS_WK_IDLE = 3'b001,
		RCS_WK_WAIT = 3'b010,
		RCS_WK_DONE = 3'b100
	} rcs_wake_t;

endpackage

// ### rtl/rcs_wdt.sv
/*
 * watchdog period counter: counts while run is high, restarts on kick,
 * gives a one-cycle expire pulse at the end of each period.
 * assumes run and kick are synchronous to clk.
 */
`timescale 1ns/100ps
module rcs_wdt #(
	parameter int unsigned PERIOD_CYC = 50000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	input wire logic run,
	input wire logic kick,
	// event
	output logic expire
);
	logic [31:0] cnt_ff; // cycles into the period
	logic expire_ff; // registered expiry pulse
	logic hit; // last cycle of the period

	assign hit = run && !kick && (cnt_ff == 32'(PERIOD_CYC - 1));
	assign expire = expire_ff;

	// period count, held at zero while stopped
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 32'h0;
		end else if (!run || kick || hit) begin
			cnt_ff <= 32'h0;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end

	// expiry pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			expire_ff <= 1'b0;
		end else begin
			expire_ff <= hit;
		end
	end
endmodule

// ### rtl/rcs_wake.sv
/*
 * wake sequencer: on a wake request either finishes at once or first
 * waits out the regulator wake delay.
 * assumes wake_req is a one-cycle pulse taken only while idle.
 */
`timescale 1ns/100ps
module rcs_wake (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// request
	input wire logic wake_req,
	input wire logic add_delay,
	// state
	output logic busy,
	output logic done
);
	import rcs_pkg::*;

	rcs_wake_t state_ff; // sequencer state
	logic [15:0] cnt_ff; // delay cycles left
	logic busy_ff; // high from request until the done cycle ends

	// both outputs come straight from flops: busy register, one-hot done bit
	assign busy = busy_ff;
	assign done = state_ff[2];

	// state, busy and delay count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= RCS_WK_IDLE;
			cnt_ff <= 16'h0;
			busy_ff <= 1'b0;
		end else begin
			case (state_ff)
				RCS_WK_IDLE: begin
					if (wake_req && add_delay) begin
						state_ff <= RCS_WK_WAIT;
						cnt_ff <= 16'(RCS_DLY_CYC - 1);
						busy_ff <= 1'b1;
					end else if (wake_req) begin
						state_ff <= RCS_WK_DONE;
						busy_ff <= 1'b1;
					end
				end
				RCS_WK_WAIT: begin
					if (cnt_ff == 16'h0) begin
						state_ff <= RCS_WK_DONE;
					end else begin
						cnt_ff <= cnt_ff - 16'h1;
					end
				end
				default: begin
					state_ff <= RCS_WK_IDLE;
					busy_ff <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ### rtl/rcs_top.sv
/*
 * reset-cause and power-state status block: sticky cause flags,
 * software watchdog enable with fuse override, retention regulator
 * control and the wake delay sequence, all behind an apb slave.
 * assumes all event and fuse inputs are synchronous to clk and that
 * event inputs are one-cycle pulses.
 */
// The register offsets and register access over APB are this design's own decisions.
// How it works
// - software enable bit runs or stops watchdog
// - watchdog expiry sets time-out flag
// - entering sleep sets sleep history flag
// - entering idle sets idle history flag
// - brown-out or power-on sets brown-out flag
// - power-on sets power-on flag
// - software may write ones and zeros to flags
// - writing flags never starts a reset
// - watchdog fuse forces watchdog always running
// - low-power fuse keeps retention regulator off
// - standby regulator adds wake delay unless skipped
`timescale 1ns/100ps
module rcs_top #(
	parameter int unsigned WDT_CYC = rcs_pkg::RCS_WDT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset and power events
	input wire logic por_event,
	input wire logic bor_event,
	input wire logic sleep_entry,
	input wire logic idle_entry,
	input wire logic wdt_kick,
	// configuration fuses
	input wire logic fuse_watchdog_force,
	input wire logic low_power_regulator_cfg,
	// regulator and wake
	input wire logic regulator_standby,
	input wire logic wake_req,
	// status out
	output logic wdt_running,
	output logic wdt_timeout,
	output logic retention_on,
	output logic wake_busy,
	output logic wake_done
);
	import rcs_pkg::*;

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	logic [5:0] cause_ff; // reset_cause_status bits 5..0
	logic [5:0] nxt_cause; // next value of cause_ff
	logic [1:0] ctrl_ff; // regulator control bits
	logic [1:0] nxt_ctrl; // next value of ctrl_ff
	logic [31:0] prdata_ff; // read data
	logic pready_ff; // access-phase answer
	logic pslverr_ff; // unmapped address
	logic wrun_ff; // watchdog running
	logic ract_ff; // retention regulator on
	logic in_sleep_ff; // asleep, waiting for wake
	logic stby_ff; // regulator went to standby this sleep
	logic [RCS_NFLAG-1:0] ev; // flag set events
	logic acc; // access phase, first cycle
	logic wr_en; // write takes effect
	logic hit_cause; // address decodes
	logic hit_ctrl;
	logic hit_stat;
	logic run_c; // watchdog run condition
	logic expire; // watchdog expiry pulse
	logic wk_busy; // wake sequencer busy
	logic wk_done; // wake sequencer finished
	logic wk_go; // wake request accepted
	logic add_dly; // wake must wait for the regulator

	// -----------------------------------------------------------------
	// apb decode
	// -----------------------------------------------------------------
	// one wait state: answer rises on the edge that ends the first access cycle
	assign acc = psel && penable && !pready_ff;
	// writes land on the edge that samples pready high
	assign wr_en = psel && penable && pwrite && pready_ff;
	assign hit_cause = (paddr == RCS_OFS_CAUSE);
	assign hit_ctrl = (paddr == RCS_OFS_CTRL);
	assign hit_stat = (paddr == RCS_OFS_STAT);

	// answer strobe and error
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= acc;
			pslverr_ff <= acc && !(hit_cause || hit_ctrl || hit_stat);
		end
	end

	// read data, captured as the answer rises; reading clears nothing
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata_ff <= 32'h0;
		end else if (acc && !pwrite) begin
			if (hit_cause) begin
				prdata_ff <= {26'h0, cause_ff};
			end else if (hit_ctrl) begin
				prdata_ff <= {30'h0, ctrl_ff};
			end else if (hit_stat) begin
				prdata_ff <= {29'h0, wk_busy, ract_ff, wrun_ff};
			end else begin
				prdata_ff <= 32'h0;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// -----------------------------------------------------------------
	// cause flags
	// -----------------------------------------------------------------
	// hardware events that set a flag
	assign ev[RCS_BIT_POR] = por_event;
	assign ev[RCS_BIT_BOR] = bor_event || por_event;
	assign ev[RCS_BIT_IDLE] = idle_entry;
	assign ev[RCS_BIT_SLEEP] = sleep_entry;
	assign ev[RCS_BIT_WATCHDOG_TIMEOUT_FLAG] = expire;

	// per flag: write stores the bit, an event in the same cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < RCS_NFLAG; gi++) begin : g_flag
			always_comb begin
				if (wr_en && hit_cause) begin
					nxt_cause[gi] = pwdata[gi] || ev[gi];
				end else begin
					nxt_cause[gi] = cause_ff[gi] || ev[gi];
				end
			end
		end
	endgenerate

	// software watchdog enable is written only by software
	always_comb begin
		if (wr_en && hit_cause) begin
			nxt_cause[RCS_BIT_SWDT] = pwdata[RCS_BIT_SWDT];
		end else begin
			nxt_cause[RCS_BIT_SWDT] = cause_ff[RCS_BIT_SWDT];
		end
	end

	// flag store; only the value changes, no reset request exists
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cause_ff <= RCS_CAUSE_RST;
		end else begin
			cause_ff <= nxt_cause;
		end
	end

	// -----------------------------------------------------------------
	// regulator control
	// -----------------------------------------------------------------
	// retention enable write has no effect while the fuse is set
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_en && hit_ctrl) begin
			nxt_ctrl = pwdata[1:0];
		end
		if (low_power_regulator_cfg) begin
			nxt_ctrl[RCS_BIT_RETENTION_REGULATOR_ENABLE] = 1'b0;
		end
	end

	// control store
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_ff <= RCS_CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// retention regulator output, masked by the fuse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ract_ff <= 1'b0;
		end else begin
			ract_ff <= ctrl_ff[RCS_BIT_RETENTION_REGULATOR_ENABLE] && !low_power_regulator_cfg;
		end
	end

	assign retention_on = ract_ff;

	// -----------------------------------------------------------------
	// watchdog
	// -----------------------------------------------------------------
	// fuse overrides the software enable
	assign run_c = fuse_watchdog_force || cause_ff[RCS_BIT_SWDT];

	// running indication
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrun_ff <= 1'b0;
		end else begin
			wrun_ff <= run_c;
		end
	end

	rcs_wdt #(
		.PERIOD_CYC(WDT_CYC)
	) u_wdt (
		.clk(clk),
		.rstn(rstn),
		.run(run_c),
		.kick(wdt_kick),
		.expire(expire)
	);

	assign wdt_running = wrun_ff;
	assign wdt_timeout = expire;

	// -----------------------------------------------------------------
	// sleep and wake
	// -----------------------------------------------------------------
	// asleep from entry until the wake sequence completes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_sleep_ff <= 1'b0;
		end else if (sleep_entry) begin
			in_sleep_ff <= 1'b1;
		end else if (wk_done) begin
			in_sleep_ff <= 1'b0;
		end
	end

	// remember a regulator standby seen during this sleep
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stby_ff <= 1'b0;
		end else if (wk_done) begin
			stby_ff <= 1'b0;
		end else if (in_sleep_ff && regulator_standby) begin
			stby_ff <= 1'b1;
		end
	end

	assign wk_go = wake_req && in_sleep_ff && !wk_busy;
	assign add_dly = stby_ff && !ctrl_ff[RCS_BIT_NODLY];

	rcs_wake u_wake (
		.clk(clk),
		.rstn(rstn),
		.wake_req(wk_go),
		.add_delay(add_dly),
		.busy(wk_busy),
		.done(wk_done)
	);

	assign wake_busy = wk_busy;
	assign wake_done = wk_done;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	localparam int WK_LO = RCS_DLY_CYC;
	localparam int WK_HI = RCS_DLY_CYC + 1;
	// done is sampled delay+1 edges after the request; eight quiet cycles come first
	localparam int WK_GAP = RCS_DLY_CYC - 7;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	swdt_run_a: assert property (
		!fuse_watchdog_force && $stable(fuse_watchdog_force)
		|=> wdt_running == $past(cause_ff[RCS_BIT_SWDT]))
		else $error("watchdog run does not follow enable bit");

	watchdog_timeout_flag_set_a: assert property (
		wdt_timeout |=> cause_ff[RCS_BIT_WATCHDOG_TIMEOUT_FLAG])
		else $error("expiry did not set time-out flag");

	sleep_set_a: assert property (
		sleep_entry |=> cause_ff[RCS_BIT_SLEEP] && in_sleep_ff)
		else $error("sleep entry not recorded");

	idle_set_a: assert property (
		idle_entry |=> cause_ff[RCS_BIT_IDLE])
		else $error("idle entry not recorded");

	bor_set_a: assert property (
		(bor_event || por_event) |=> cause_ff[RCS_BIT_BOR])
		else $error("brown-out flag not set");

	por_set_a: assert property (
		por_event |=> cause_ff[RCS_BIT_POR] && cause_ff[RCS_BIT_BOR])
		else $error("power-on flags not set");

	flag_write_a: assert property (
		wr_en && hit_cause && !por_event && !bor_event && !idle_entry
		&& !sleep_entry && !expire |=> cause_ff == $past(pwdata[5:0]))
		else $error("flag write not stored");

	no_reset_a: assert property (
		wr_en && hit_cause && !low_power_regulator_cfg
		|=> ctrl_ff == $past(ctrl_ff) && !pready)
		else $error("flag write disturbed other state");

	fuse_wdt_a: assert property (
		fuse_watchdog_force |=> wdt_running)
		else $error("fuse did not force watchdog");

	ret_off_a: assert property (
		low_power_regulator_cfg |=> !ctrl_ff[RCS_BIT_RETENTION_REGULATOR_ENABLE] && !retention_on)
		else $error("retention on despite fuse");

	wake_dly_a: assert property (
		wk_go && add_dly |=> !wk_done [*8] ##[WK_GAP:WK_GAP] wk_done)
		else $error("wake delay length wrong");

	flag_hold_a: assert property (
		!(wr_en && hit_cause) && ev == '0 |=> $stable(cause_ff))
		else $error("flag changed without cause");

	wdt_stop_a: assert property (
		!run_c |=> !wdt_timeout)
		else $error("expiry while watchdog stopped");

	wake_clr_a: assert property (
		wk_done && !sleep_entry |=> !in_sleep_ff && !stby_ff && !wake_busy)
		else $error("wake end did not clear sleep state");

	wake_fast_c: cover property (wk_go && !add_dly ##1 wk_done);
	wake_slow_c: cover property (wk_go && add_dly ##[WK_LO:WK_HI] wk_done);
	wdt_exp_c: cover property (wdt_timeout);
	err_c: cover property (pslverr && pready);
	ret_fused_c: cover property (low_power_regulator_cfg && wr_en && hit_ctrl
		&& pwdata[RCS_BIT_RETENTION_REGULATOR_ENABLE]);
endmodule

// ### verification/tb_rcs_top.sv
/*
 * self-checking bench for rcs_top: register access over apb, event
 * flags, watchdog with fuse override, retention control, wake delay.
 * assumes rcs_pkg is compiled first; no partner model.
 */
`timescale 1ns/100ps
module tb_rcs_top;
	import rcs_pkg::*;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam int WCYC = 20; // shortened watchdog period
	typedef struct {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic err;
	} rcs_row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] ev = 4'h0; // por, bor, idle, sleep pulses
	logic kick = 1'b0;
	logic fuse_force = 1'b0;
	logic lp_cfg = 1'b0;
	logic stby = 1'b0;
	logic wreq = 1'b0;
	logic wdt_running;
	logic wdt_timeout;
	logic retention_on;
	logic wake_busy;
	logic wake_done;
	int err_count = 0;
	int checks = 0;
	int to_cnt = 0; // watchdog pulses seen
	int n;
	logic [31:0] rd;
	logic er;
	logic [31:0] ev_exp [4] = '{32'h03, 32'h02, 32'h04, 32'h08};
	rcs_row_t rows [8] = '{
		'{1'b1, RCS_OFS_CTRL, 32'h2, 32'h2, 1'b0},
		'{1'b1, RCS_OFS_CAUSE, 32'h0, 32'h0, 1'b0},
		'{1'b1, RCS_OFS_CAUSE, 32'hffffffff, 32'h3f, 1'b0},
		'{1'b1, RCS_OFS_CAUSE, 32'h1f, 32'h1f, 1'b0},
		'{1'b0, RCS_OFS_CTRL, 32'h0, 32'h2, 1'b0},
		'{1'b1, RCS_OFS_CAUSE, 32'h0a, 32'h0a, 1'b0},
		'{1'b1, RCS_OFS_STAT, 32'h7, 32'h0, 1'b0},
		'{1'b1, 8'h0c, 32'hffffffff, 32'h0, 1'b1}
	};

	// 50 MHz clock
	always #10 clk = ~clk;

	// count watchdog pulses
	always @(posedge clk) begin
		to_cnt <= to_cnt + int'(wdt_timeout === 1'b1);
	end

	rcs_top #(.WDT_CYC(WCYC)) i_rcs_top (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .por_event(ev[0]), .bor_event(ev[1]),
		.idle_entry(ev[2]), .sleep_entry(ev[3]), .wdt_kick(kick),
		.fuse_watchdog_force(fuse_force), .low_power_regulator_cfg(lp_cfg),
		.regulator_standby(stby), .wake_req(wreq), .wdt_running(wdt_running),
		.wdt_timeout(wdt_timeout), .retention_on(retention_on),
		.wake_busy(wake_busy), .wake_done(wake_done)
	);

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	// verdict and end of run
	task automatic finish_test();
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// a wait that ran out counts as a mismatch
	task automatic hang();
		err_count++;
		finish_test();
	endtask

	// compare one value
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer: setup, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (k > 50) hang();
		end while (pready !== 1'b1);
		// read before this edge's updates land, so data stand with pready
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rd, er);
		chk(what, exp, rd);
	endtask

	// one-cycle event pulse
	task automatic pulse_ev(input logic [3:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
	endtask

	// count cycles until timeout (w=0) or wake done (w=1)
	task automatic wait_hi(input int w, output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
			if (k > 2000) hang();
		end while ((w == 0 ? wdt_timeout : wake_done) !== 1'b1);
	endtask

	// sleep, then a wake request; cycles until done
	task automatic wake_run(input logic [31:0] ctrl, output int k);
		wr(RCS_OFS_CTRL, ctrl);
		pulse_ev(4'h8);
		@(posedge clk);
		wreq <= 1'b1;
		@(posedge clk);
		wreq <= 1'b0;
		wait_hi(1, k);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		// table of plain register accesses
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				apb(1'b1, rows[i].a, rows[i].d, rd, er);
				chk("write error", {31'h0, rows[i].err}, {31'h0, er});
			end
			apb(1'b0, rows[i].a, 32'h0, rd, er);
			chk("read data", rows[i].exp, rd);
			chk("read error", {31'h0, rows[i].err}, {31'h0, er});
		end
		// each event sets its flags, reads do not clear them
		for (int i = 0; i < 4; i++) begin
			wr(RCS_OFS_CAUSE, 32'h0);
			pulse_ev(4'h1 << i);
			rd_chk("event flags", RCS_OFS_CAUSE, ev_exp[i]);
			rd_chk("flags reread", RCS_OFS_CAUSE, ev_exp[i]);
		end
		// software enable runs the watchdog
		wr(RCS_OFS_CAUSE, 32'h20);
		wait_hi(0, n);
		wait_hi(0, n);
		chk("wdt period", WCYC, n);
		rd_chk("timeout flag", RCS_OFS_CAUSE, 32'h30);
		// cleared enable stops it
		wr(RCS_OFS_CAUSE, 32'h0);
		n = to_cnt;
		repeat (3 * WCYC) @(posedge clk);
		chk("stopped pulses", n, to_cnt);
		chk("stopped running", 32'h0, {31'h0, wdt_running});
		// fuse forces it on with enable clear; kicks hold it off
		@(posedge clk);
		fuse_force <= 1'b1;
		wait_hi(0, n);
		wait_hi(0, n);
		chk("forced period", WCYC, n);
		rd_chk("forced status", RCS_OFS_STAT, 32'h1);
		n = to_cnt;
		repeat (6) begin
			@(posedge clk);
			kick <= 1'b1;
			@(posedge clk);
			kick <= 1'b0;
			repeat (8) @(posedge clk);
		end
		chk("kicked pulses", n, to_cnt);
		@(posedge clk);
		fuse_force <= 1'b0;
		// low-power fuse keeps retention off
		@(posedge clk);
		lp_cfg <= 1'b1;
		wr(RCS_OFS_CTRL, 32'h1);
		rd_chk("retention fused", RCS_OFS_CTRL, 32'h0);
		chk("retention out", 32'h0, {31'h0, retention_on});
		@(posedge clk);
		lp_cfg <= 1'b0;
		wr(RCS_OFS_CTRL, 32'h1);
		rd_chk("retention set", RCS_OFS_CTRL, 32'h1);
		rd_chk("retention status", RCS_OFS_STAT, 32'h2);
		// wake with and without the regulator delay
		@(posedge clk);
		stby <= 1'b1;
		wake_run(32'h1, n);
		chk("wake delayed", RCS_DLY_CYC + 1, n);
		chk("busy at done", 32'h1, {31'h0, wake_busy});
		wake_run(32'h3, n);
		chk("wake skipped", 32'h1, n);
		@(posedge clk);
		stby <= 1'b0;
		wake_run(32'h1, n);
		chk("wake no standby", 32'h1, n);
		// reset in mid-run restores power-on flags
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		chk("reset outputs", 32'h0, {27'h0, pready, wdt_running, retention_on,
			wake_busy, wake_done});
		rstn <= 1'b1;
		rd_chk("reset cause", RCS_OFS_CAUSE, 32'h03);
		rd_chk("reset ctrl", RCS_OFS_CTRL, 32'h0);
		finish_test();
	end
endmodule
